// ===== hw/srh_sync2.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// two-stage synchroniser for pin inputs
// ------------------------------------------------------------
module srh_sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule // srh_sync2

`default_nettype wire

// ===== hw/srh_conv_seq.sv
// What this block does
// - open config: avoid both-armed 11.5-25 us
// - other configs: avoid both-armed 6.5-15 us
// - burst idle: both armed beyond upper bound
// - switching dead time below lower bound
package srh_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS         = 40;
  localparam int WIN_LO_NS_OPEN = 11500;
  localparam int WIN_HI_NS_OPEN = 25000;
  localparam int WIN_LO_NS_THRESHOLD_SELECT_PIN = 6500;
  localparam int WIN_HI_NS_THRESHOLD_SELECT_PIN = 15000;
  // a both-armed span must stay strictly below the lower bound
  localparam int WIN_LO_CYC_OPEN = WIN_LO_NS_OPEN / CLK_NS;
  localparam int WIN_LO_CYC_THRESHOLD_SELECT_PIN = WIN_LO_NS_THRESHOLD_SELECT_PIN / CLK_NS;
  // or strictly above the upper bound
  localparam int WIN_HI_CYC_OPEN = (WIN_HI_NS_OPEN + CLK_NS - 1) / CLK_NS;
  localparam int WIN_HI_CYC_THRESHOLD_SELECT_PIN = (WIN_HI_NS_THRESHOLD_SELECT_PIN + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // sequencer states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_OFF    = 6'b000001,
    ST_COND_A = 6'b000010,
    ST_DEAD_A = 6'b000100,
    ST_COND_B = 6'b001000,
    ST_DEAD_B = 6'b010000,
    ST_HOLD   = 6'b100000
  } srh_state_t;

endpackage

`timescale 1ns/100ps
`default_nettype none

module srh_conv_seq import srh_pkg::*; #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run_req,
  input  wire logic             burst_req,
  input  wire logic             stop_req,
  input  wire logic             threshold_select_pin_open,
  input  wire logic [CNT_W-1:0] half_period,
  input  wire logic [CNT_W-1:0] dead_time,
  input  wire logic             fault_clr,
  input  wire logic             gate_drive_a,
  input  wire logic             gate_drive_b,
  output var  logic             drain_sense_a,
  output var  logic             drain_sense_b,
  output var  logic             enable_out,
  output var  logic             enable_oe,
  output var  logic             switching,
  output var  logic             gap_illegal,
  output var  logic             fault_overlap
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  generate
    if (CNT_W < 11 || CNT_W > 31) begin : g_bad_width
      $error("CNT_W must hold the window bounds");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LO_OPEN = CNT_W'(WIN_LO_CYC_OPEN);
  localparam logic [CNT_W-1:0] LO_THRESHOLD_SELECT_PIN = CNT_W'(WIN_LO_CYC_THRESHOLD_SELECT_PIN);
  localparam logic [CNT_W-1:0] HI_OPEN = CNT_W'(WIN_HI_CYC_OPEN);
  localparam logic [CNT_W-1:0] HI_THRESHOLD_SELECT_PIN = CNT_W'(WIN_HI_CYC_THRESHOLD_SELECT_PIN);
  localparam logic [CNT_W-1:0] ONE     = CNT_W'(1);
  localparam logic [CNT_W-1:0] MAXC    = '1;

  srh_state_t       state_r;
  srh_state_t       state_nxt;
  logic [CNT_W-1:0] tmr_r;
  logic [CNT_W-1:0] gap_r;
  logic [CNT_W-1:0] lo_cyc;
  logic [CNT_W-1:0] hi_cyc;
  logic [CNT_W-1:0] dead_eff;
  logic [CNT_W-1:0] half_eff;
  logic [1:0]       gate_s;
  logic             both_hi;
  logic             hold_ok;
  logic             burst_seen_r;

  // ------------------------------------------------------------
  // gate feedback from the device
  // ------------------------------------------------------------
  srh_sync2 #(
    .WIDTH(2)
  ) u_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  ({gate_drive_b, gate_drive_a}),
    .dout (gate_s)
  );

  // span in which a both-armed interval must not end
  always_comb begin
    lo_cyc = threshold_select_pin_open ? LO_OPEN : LO_THRESHOLD_SELECT_PIN;
    hi_cyc = threshold_select_pin_open ? HI_OPEN : HI_THRESHOLD_SELECT_PIN;
  end

  // dead time is clipped so switching never reaches the window
  always_comb begin
    if (dead_time >= lo_cyc - ONE) begin
      dead_eff = lo_cyc - ONE - ONE;
    end else if (dead_time == '0) begin
      dead_eff = ONE;
    end else begin
      dead_eff = dead_time;
    end
    half_eff = (half_period < ONE + ONE) ? ONE + ONE : half_period;
  end

  assign both_hi = drain_sense_a && drain_sense_b;

  // burst idle must run past the upper bound; a short protection
  // stop may also end before the lower bound
  always_comb begin
    if (burst_req) begin
      hold_ok = 1'b0;
    end else if (gap_r > hi_cyc) begin
      hold_ok = 1'b1;
    end else if (burst_seen_r) begin
      hold_ok = 1'b0;
    end else begin
      hold_ok = (gap_r < lo_cyc - ONE) && !stop_req;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_OFF: begin
        if (run_req) begin
          state_nxt = ST_COND_A;
        end
      end
      ST_COND_A: begin
        if (burst_req || stop_req) begin
          state_nxt = ST_HOLD;
        end else if (tmr_r >= half_eff - dead_eff) begin
          state_nxt = ST_DEAD_A;
        end
      end
      ST_DEAD_A: begin
        if (burst_req || stop_req) begin
          state_nxt = ST_HOLD;
        end else if (tmr_r >= dead_eff) begin
          state_nxt = ST_COND_B;
        end
      end
      ST_COND_B: begin
        if (burst_req || stop_req) begin
          state_nxt = ST_HOLD;
        end else if (tmr_r >= half_eff - dead_eff) begin
          state_nxt = ST_DEAD_B;
        end
      end
      ST_DEAD_B: begin
        if (burst_req || stop_req) begin
          state_nxt = ST_HOLD;
        end else if (tmr_r >= dead_eff) begin
          state_nxt = ST_COND_A;
        end
      end
      ST_HOLD: begin
        if (hold_ok) begin
          state_nxt = ST_COND_A;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // dropping run leaves the drains low, so no armed span remains
    if (!run_req) begin
      state_nxt = ST_OFF;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // a hold that saw burst may only end past the upper bound or when run drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_seen_r <= 1'b0;
    end else begin
      burst_seen_r <= (state_nxt == ST_HOLD) && (burst_seen_r || burst_req);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= ONE;
    end else if (tmr_r != MAXC) begin
      tmr_r <= tmr_r + ONE;
    end
  end

  // ------------------------------------------------------------
  // drain level outputs: high means above the arming level
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      drain_sense_a <= 1'b0;
      drain_sense_b <= 1'b0;
      switching     <= 1'b0;
    end else begin
      drain_sense_a <= state_nxt inside {ST_DEAD_A, ST_COND_B,
                                         ST_DEAD_B, ST_HOLD};
      drain_sense_b <= state_nxt inside {ST_COND_A, ST_DEAD_A,
                                         ST_DEAD_B, ST_HOLD};
      switching     <= state_nxt inside {ST_COND_A, ST_DEAD_A,
                                         ST_COND_B, ST_DEAD_B};
    end
  end

  // length of the current both-armed span, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_r <= '0;
    end else if (!both_hi) begin
      gap_r <= '0;
    end else if (gap_r != MAXC) begin
      gap_r <= gap_r + ONE;
    end
  end

  // flags a span that ended inside the window; should never fire
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_illegal <= 1'b0;
    end else begin
      gap_illegal <= !both_hi && gap_r >= lo_cyc && gap_r <= hi_cyc;
    end
  end

  // ------------------------------------------------------------
  // enable pin: pulled low to force low consumption, else open
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_out <= 1'b0;
      enable_oe  <= 1'b1;
    end else begin
      enable_out <= 1'b0;
      enable_oe  <= !run_req;
    end
  end

  // device keeps the gates apart; watch for a breach
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_overlap <= 1'b0;
    end else if (gate_s[0] && gate_s[1]) begin
      fault_overlap <= 1'b1;
    end else if (fault_clr) begin
      fault_overlap <= 1'b0;
    end
  end

endmodule // srh_conv_seq

`default_nettype wire

// ===== dv/srh_conv_seq_sva.sv
`timescale 1ns/100ps
`default_nettype none
module srh_conv_seq_sva import srh_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_req,
  input wire logic burst_req,
  input wire logic threshold_select_pin_open,
  input wire logic fault_clr,
  input wire logic gate_drive_a,
  input wire logic gate_drive_b,
  input wire logic drain_sense_a,
  input wire logic drain_sense_b,
  input wire logic enable_out,
  input wire logic enable_oe,
  input wire logic switching,
  input wire logic fault_overlap
);
  int   span_r;
  int   lo;
  int   hi;
  logic both;
  logic any;
  assign both = drain_sense_a && drain_sense_b;
  assign any = drain_sense_a || drain_sense_b;
  assign lo = threshold_select_pin_open ? WIN_LO_CYC_OPEN : WIN_LO_CYC_THRESHOLD_SELECT_PIN;
  assign hi = threshold_select_pin_open ? WIN_HI_CYC_OPEN : WIN_HI_CYC_THRESHOLD_SELECT_PIN;
  // both-high cycles seen so far in the current span
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      span_r <= 0;
    else
      span_r <= both ? span_r + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_en; enable_out == 1'b0; endproperty
  a_en: assert property (p_en) else $error("enable driven high");
  property p_off; !run_req |=> !any && enable_oe && !switching; endproperty
  a_off: assert property (p_off) else $error("not idle");
  property p_alt; switching |-> any; endproperty
  a_alt: assert property (p_alt) else $error("both drains low");
  property p_burst;
    switching && run_req && burst_req |=> both && !switching;
  endproperty
  a_burst: assert property (p_burst) else $error("no burst hold");
  property p_win; both && run_req ##1 !both |-> span_r <= lo || span_r > hi;
  endproperty
  a_win: assert property (p_win) else $error("span in window");
  property p_dead; switching && both |-> span_r < lo; endproperty
  a_dead: assert property (p_dead) else $error("dead span long");
  property p_ovl;
    (gate_drive_a && gate_drive_b) [*3] |-> ##[0:2] fault_overlap;
  endproperty
  a_ovl: assert property (p_ovl) else $error("overlap missed");
  property p_keep; fault_overlap && !fault_clr |=> fault_overlap; endproperty
  a_keep: assert property (p_keep) else $error("overlap lost");
endmodule // srh_conv_seq_sva
bind srh_conv_seq srh_conv_seq_sva u_sva (.*);
`default_nettype wire

// ===== dv/srh_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// gates follow their own drain; bad forces an overlap on command only
module srh_dev_model (
  input  wire logic clk,
  input  wire logic undervoltage_lockout,
  input  wire logic bad,
  input  wire logic threshold_select_pin_open,
  input  wire logic enable_oe,
  input  wire logic drain_sense_a,
  input  wire logic drain_sense_b,
  output var  logic gate_drive_a = 1'b0,
  output var  logic gate_drive_b = 1'b0
);
  int   ca = 0;
  int   cb = 0;
  int   per = 0;
  int   hp = 40;
  int   ba = 0;
  int   bb = 0;
  int   bm_duty;
  int   slp_duty;
  logic pa = 1'b0;
  logic pb = 1'b0;
  logic arm_a = 1'b0;
  logic arm_b = 1'b0;
  logic slp = 1'b1;
  logic off;
  assign off = undervoltage_lockout || enable_oe;
  // restart thresholds picked by the select input
  assign bm_duty = threshold_select_pin_open ? 0 : 80;
  assign slp_duty = threshold_select_pin_open ? 55 : 60;
  // third machine: low consumption follows the off causes
  always @(posedge clk)
    slp <= off;
  always @(posedge clk) begin
    pa <= drain_sense_a;
    per <= per + 1;
    if (pa && !drain_sense_a) begin
      hp <= per / 2;
      per <= 1;
    end
    pb <= drain_sense_b;
    if (drain_sense_b && !pb)
      arm_a <= 1'b1;
    else if (gate_drive_a)
      arm_a <= 1'b0;
    if (drain_sense_a && !pa)
      arm_b <= 1'b1;
    else if (gate_drive_b)
      arm_b <= 1'b0;
    // count restarts at the falling (pretrigger) crossing
    ca <= drain_sense_a ? 0 : ca + 1;
    cb <= drain_sense_b ? 0 : cb + 1;
    ba <= gate_drive_a ? ba + 1 : 0;
    bb <= gate_drive_b ? bb + 1 : 0;
    // mask of 30 percent stays under the 40 percent cap; a longer
    // measured period gives a longer mask
    gate_drive_a <= bad || (!off && !drain_sense_a && !gate_drive_b
                    && (arm_a || gate_drive_a)
                    && (ca >= hp * 3 / 10
                    || ba < hp / 2));
    gate_drive_b <= bad || (!off && !drain_sense_b && !gate_drive_a
                    && (arm_b || gate_drive_b)
                    && (cb >= hp * 3 / 10
                    || bb < hp / 2));
  end
endmodule // srh_dev_model
`default_nettype wire

// ===== dv/srh_conv_seq_bench.sv
`timescale 1ns/100ps
`default_nettype none
module srh_conv_seq_bench;
  import srh_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, run_req = 1'b0, burst_req = 1'b0;
  logic stop_req = 1'b0, threshold_select_pin_open = 1'b0, fault_clr = 1'b0;
  logic undervoltage_lockout = 1'b1, bad = 1'b0;
  logic [15:0] half_period = 16'h0028, dead_time = 16'h0004;
  wire logic gate_drive_a, gate_drive_b, drain_sense_a, drain_sense_b;
  wire logic enable_out, enable_oe, switching, gap_illegal, fault_overlap;
  wire logic [4:0] st = {drain_sense_a, drain_sense_b, enable_oe,
                         enable_out, switching};
  int failures = 0, cmp_count = 0, cyc = 0, span = 0, lo, hi, de;
  int spans[$];
  srh_conv_seq DUT (.*);
  srh_dev_model dev (.*);
  always #20 clk = ~clk;
  assign lo = threshold_select_pin_open ? WIN_LO_CYC_OPEN : WIN_LO_CYC_THRESHOLD_SELECT_PIN;
  assign hi = threshold_select_pin_open ? WIN_HI_CYC_OPEN : WIN_HI_CYC_THRESHOLD_SELECT_PIN;
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // every clock wait runs through here (the #1 delays do not), so the cycle ceiling covers all hangs
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      cyc++;
      if (cyc > 20000) begin
        failures++;
        end_of_test();
      end
    end
  endtask
  // model: log each both-high span that ends while running
  always @(posedge clk) begin
    if (gap_illegal === 1'b1)
      chk(0, "gap flagged");
    if (drain_sense_a === 1'b1 && drain_sense_b === 1'b1)
      span <= span + 1;
    else begin
      if (span > 0 && run_req) begin
        spans.push_back(span);
        chk(span <= lo || span > hi, "span in window");
      end
      span <= 0;
    end
  end
  // ------
  // scenarios
  // ------
  initial begin
    void'($urandom(32'h3008));
    tick(2);
    rst_n <= 1'b1;
    undervoltage_lockout <= 1'b0;
    tick(1);
    #1 chk(st === 5'h04, "idle after reset");
    for (int i = 0; i < 3; i++) begin
      tick(1);
      threshold_select_pin_open <= i[0];
      half_period <= (i == 2) ? 16'h0190 : 16'h0028 + 16'($urandom % 40);
      dead_time <= (i == 2) ? 16'h01f4 : 16'h0001 + 16'($urandom % 24);
      run_req <= 1'b1;
      tick(1);
      de = dead_time > lo - 2 ? lo - 2 : dead_time;
      tick(4 * half_period);
      spans.delete();
      tick(6 * half_period);
      #1 chk(st[2] === 1'b0 && spans.size() > 2, "no switching");
      foreach (spans[k])
        chk(spans[k] >= de && spans[k] <= de + 1, "dead time");
      tick(1);
      run_req <= 1'b0;
      tick(1);
      #1 chk(st === 5'h04, "not off");
    end
    for (int i = 0; i < 2; i++) begin
      tick(1);
      threshold_select_pin_open <= i[0];
      half_period <= 16'h0028;
      dead_time <= 16'h0004;
      run_req <= 1'b1;
      tick(200);
      burst_req <= 1'b1;
      tick(100);
      #1 chk(st === 5'h18, "burst hold");
      tick(1);
      spans.delete();
      burst_req <= 1'b0;
      tick(800);
      chk(spans.size() > 0 && spans[0] > hi, "burst exit");
      stop_req <= 1'b1;
      tick(30);
      stop_req <= 1'b0;
      tick(200);
      #1 chk(st[0] === 1'b1, "short stop exit");
      tick(1);
      run_req <= 1'b0;
    end
    tick(1);
    run_req <= 1'b1;
    tick(50);
    #1 chk(fault_overlap === 1'b0, "false overlap");
    tick(1);
    bad <= 1'b1;
    tick(6);
    #1 chk(fault_overlap === 1'b1, "overlap missed");
    tick(1);
    bad <= 1'b0;
    tick(4);
    fault_clr <= 1'b1;
    tick(1);
    fault_clr <= 1'b0;
    tick(2);
    #1 chk(fault_overlap === 1'b0, "overlap kept");
    end_of_test();
  end
endmodule // srh_conv_seq_bench
`default_nettype wire
